// >>> swr_pkg.sv
// Shared constants, types and register map of the supervisor watchdog reset block
package swr_pkg;

    // Clock rate
    localparam int unsigned CLK_KHZ = 20000;

    // Timing figures in their own units
    localparam int unsigned T_RST_MS = 200;
    localparam int unsigned T_WD_OPEN_MS = 1600;
    localparam int unsigned T_WD_PULLUP_MS = 200;
    localparam int unsigned T_EVAL_US = 381;

    // Cycle counts derived from the figures
    localparam int unsigned RST_HOLD_CYC = T_RST_MS * CLK_KHZ;
    localparam int unsigned WD_OPEN_CYC = T_WD_OPEN_MS * CLK_KHZ;
    localparam int unsigned WD_PULLUP_CYC = T_WD_PULLUP_MS * CLK_KHZ;
    localparam int unsigned EVAL_CYC = (T_EVAL_US * CLK_KHZ + 999) / 1000;

    // Capacitor timing laws: multipliers in watchdog cycles per charge cycle, extended base in watchdog cycles
    localparam int unsigned CAP_STD_MULT = 64;
    localparam int unsigned CAP_EXT_MULT = 1536;
    localparam int unsigned CAP_EXT_BASE = 1250000;

    // Register byte offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_TIMEOUT = 8'h04;
    localparam logic [7:0] REG_CHARGE = 8'h08;
    localparam logic [7:0] REG_FAULT_CNT = 8'h0c;
    localparam logic [7:0] REG_CTRL = 8'h10;

    // Field positions
    localparam int unsigned CTRL_INHIBIT_BIT = 0;
    localparam int unsigned ST_RESET_BIT = 0;
    localparam int unsigned ST_FAULT_BIT = 1;
    localparam int unsigned ST_WDEN_BIT = 2;
    localparam int unsigned ST_EVAL_BIT = 3;
    localparam int unsigned ST_EXT_BIT = 4;
    localparam int unsigned ST_MODE_LSB = 5;

    // Reset values
    localparam logic CTRL_RESET = 1'b0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Configuration pin modes
    typedef enum logic [1:0] {
        SWR_CFG_OPEN = 2'b00,
        SWR_CFG_PULLUP = 2'b01,
        SWR_CFG_CAP = 2'b10
    } swr_cfg_mode_t;

    // Result of the configuration pin evaluation
    typedef struct packed {
        logic done;
        swr_cfg_mode_t mode;
        logic [15:0] charge;
    } swr_cfg_t;

endpackage

// >>> swr_cfg_eval.sv
// Evaluation of the timeout configuration pin after startup
`timescale 1ns/10ps
module swr_cfg_eval #(
    parameter int unsigned EVAL_CYCLES = swr_pkg::EVAL_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic timeout_cfg_pin,
    input wire logic timeout_cfg_pullup,
    output swr_pkg::swr_cfg_t cfg
);

    logic [31:0] eval_cnt_r;
    logic first_r;
    logic done_r;
    swr_pkg::swr_cfg_mode_t mode_r;
    logic [15:0] charge_r;

    // sample window
    // Count the evaluation window once after power-on, then set done and stop counting
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            eval_cnt_r <= 32'h0000_0000;
            done_r <= 1'b0;
        end else if (!done_r) begin
            if (eval_cnt_r >= EVAL_CYCLES - 1) begin
                done_r <= 1'b1;
            end else begin
                eval_cnt_r <= eval_cnt_r + 32'h0000_0001;
            end
        end
    end

    // pin mode decode
    // A pin that is low at the first sample is a capacitor still charging
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            first_r <= 1'b1;
            mode_r <= swr_pkg::SWR_CFG_OPEN;
        end else if (first_r) begin
            first_r <= 1'b0;
            if (!timeout_cfg_pin) begin
                mode_r <= swr_pkg::SWR_CFG_CAP;
            end else if (timeout_cfg_pullup) begin
                mode_r <= swr_pkg::SWR_CFG_PULLUP;
            end else begin
                mode_r <= swr_pkg::SWR_CFG_OPEN;
            end
        end
    end

    // Charge time is measured while the pin stays below threshold; it saturates
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            charge_r <= 16'h0000;
        end else if (!done_r && !timeout_cfg_pin && charge_r != 16'hffff) begin
            charge_r <= charge_r + 16'h0001;
        end
    end

    assign cfg.done = done_r;
    assign cfg.mode = mode_r;
    assign cfg.charge = charge_r;

endmodule

// >>> swr_top.sv
// Supervisor reset, watchdog timer and AXI4-Lite status registers
// Behaviour
// - Reset asserts while manual reset is low.
// - After manual reset rises, reset holds for the hold time.
// - Undervoltage flag asserts reset at once.
// - Supply good starts hold counter; reset releases when done.
// - From power-up reset holds until supply good and hold elapsed.
// - Enable-select low disables the watchdog.
// - Timeout chosen from enable-select and configuration pin; the code chooses it from the configuration pin mode alone.
// - Capacitor gives user timeout; pull-up or open gives presets.
// - Capacitor timeout uses standard or extended law per variant.
// - Kicks ignored while reset or fault low, or watchdog disabled.
// - Expiry asserts fault only while reset is released.
// - Each fault pulse lasts the hold time.
// - Reset asserting releases the fault output.
// - Configuration pin is evaluated after startup before mode fixes.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module swr_top #(
    parameter int unsigned RST_HOLD_CYCLES = swr_pkg::RST_HOLD_CYC,
    parameter int unsigned WD_OPEN_CYCLES = swr_pkg::WD_OPEN_CYC,
    parameter int unsigned WD_PULLUP_CYCLES = swr_pkg::WD_PULLUP_CYC,
    parameter int unsigned EVAL_CYCLES = swr_pkg::EVAL_CYC,
    parameter int unsigned CAP_EXT_BASE = swr_pkg::CAP_EXT_BASE,
    parameter bit EXTENDED_TIMING = 1'b0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic manual_reset_n,
    input wire logic manual_reset_drive,
    input wire logic uv_flag,
    input wire logic wd_enable_select,
    input wire logic timeout_cfg_pin,
    input wire logic timeout_cfg_pullup,
    input wire logic wd_kick_in,
    output logic sys_reset_n_o,
    output logic sys_reset_n_oe,
    output logic wd_fault_n_o,
    output logic wd_fault_n_oe,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [1:0] {RST_HOLD = 2'b00, RST_DELAY = 2'b01, RST_RUN = 2'b11}
        swr_rst_state_t;
    typedef enum logic [1:0] {WD_EVAL = 2'b00, WD_OFF = 2'b01, WD_ARMED = 2'b11, WD_FAULT = 2'b10}
        swr_wd_state_t;
    swr_pkg::swr_cfg_t cfg;
    swr_rst_state_t rst_state_r, rst_state_nxt;
    swr_wd_state_t wd_state_r, wd_state_nxt;
    logic [31:0] rst_cnt_r, wd_cnt_r, fault_cnt_r, timeout_cyc, w_data_r, rdata_r;
    logic [15:0] fault_events_r;
    logic kick_prev_r, rst_oe_r, fault_oe_r, inhibit_r;
    logic mr_level, rst_cause, kick_fall, wd_enabled;
    logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [7:0] aw_addr_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;
    // Register decode shared by the read and write paths
    function automatic logic reg_mapped(input logic [7:0] addr);
        reg_mapped = (addr == swr_pkg::REG_STATUS) || (addr == swr_pkg::REG_TIMEOUT) ||
                     (addr == swr_pkg::REG_CHARGE) || (addr == swr_pkg::REG_FAULT_CNT) ||
                     (addr == swr_pkg::REG_CTRL);
    endfunction

    swr_cfg_eval #(
        .EVAL_CYCLES(EVAL_CYCLES)
    ) u_cfg_eval (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .timeout_cfg_pin(timeout_cfg_pin),
        .timeout_cfg_pullup(timeout_cfg_pullup),
        .cfg(cfg)
    );

    // internal pull-up
    // An undriven manual reset pin reads high
    assign mr_level = manual_reset_drive ? manual_reset_n : 1'b1;
    assign rst_cause = !mr_level || uv_flag;

    // supervisor sequencing
    // Any cause during the delay restarts the whole hold period
    always_comb begin
        rst_state_nxt = rst_state_r;
        case (rst_state_r)
            RST_HOLD: if (!rst_cause) rst_state_nxt = RST_DELAY;
            RST_DELAY: begin
                if (rst_cause) rst_state_nxt = RST_HOLD;
                else if (rst_cnt_r >= RST_HOLD_CYCLES - 1) rst_state_nxt = RST_RUN;
            end
            RST_RUN: if (rst_cause) rst_state_nxt = RST_HOLD;
            default: rst_state_nxt = RST_HOLD;
        endcase
    end
    // power-up hold
    // Asynchronous reset parks the supervisor in hold with reset driven
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_state_r <= RST_HOLD;
            rst_oe_r <= 1'b1;
        end else begin
            rst_state_r <= rst_state_nxt;
            rst_oe_r <= (rst_state_nxt != RST_RUN);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_cnt_r <= 32'h0000_0000;
        end else if (rst_state_r == RST_DELAY && rst_state_nxt == RST_DELAY) begin
            rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
        end else begin
            rst_cnt_r <= 32'h0000_0000;
        end
    end

    // timeout selection
    // Presets depend only on the configuration mode, not on enable-select; a zero timeout is forced to one
    always_comb begin
        case (cfg.mode)
            swr_pkg::SWR_CFG_PULLUP: timeout_cyc = WD_PULLUP_CYCLES;
            swr_pkg::SWR_CFG_CAP: timeout_cyc = EXTENDED_TIMING ?
                CAP_EXT_BASE + {16'h0000, cfg.charge} * swr_pkg::CAP_EXT_MULT :
                {16'h0000, cfg.charge} * swr_pkg::CAP_STD_MULT;
            default: timeout_cyc = WD_OPEN_CYCLES;
        endcase
        if (timeout_cyc == 32'h0000_0000) timeout_cyc = 32'h0000_0001;
    end
    assign wd_enabled = wd_enable_select && !inhibit_r && cfg.done;

    // kick qualification
    // Edges count only in the armed state, which needs reset released
    assign kick_fall = kick_prev_r && !wd_kick_in && (wd_state_r == WD_ARMED);

    // Previous kick level; resets to the idle high so reset makes no false edge
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            kick_prev_r <= 1'b1;
        end else begin
            kick_prev_r <= wd_kick_in;
        end
    end

    // Watchdog sequencing; reset taking over always wins over a running fault
    always_comb begin
        wd_state_nxt = wd_state_r;
        case (wd_state_r)
            WD_EVAL: if (cfg.done) wd_state_nxt = WD_OFF;
            WD_OFF: if (wd_enabled && rst_state_nxt == RST_RUN) wd_state_nxt = WD_ARMED;
            WD_ARMED: begin
                if (!wd_enabled || rst_state_nxt != RST_RUN) wd_state_nxt = WD_OFF;
                else if (!kick_fall && wd_cnt_r >= timeout_cyc - 1) wd_state_nxt = WD_FAULT;
            end
            WD_FAULT: begin
                if (rst_state_nxt != RST_RUN) wd_state_nxt = WD_OFF;
                else if (fault_cnt_r >= RST_HOLD_CYCLES - 1)
                    wd_state_nxt = wd_enabled ? WD_ARMED : WD_OFF;
            end
            default: wd_state_nxt = WD_OFF;
        endcase
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wd_state_r <= WD_EVAL;
            fault_oe_r <= 1'b0;
        end else begin
            wd_state_r <= wd_state_nxt;
            fault_oe_r <= (wd_state_nxt == WD_FAULT);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wd_cnt_r <= 32'h0000_0000;
        end else if (wd_state_nxt != WD_ARMED || wd_state_r != WD_ARMED || kick_fall) begin
            wd_cnt_r <= 32'h0000_0000;
        end else begin
            wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fault_cnt_r <= 32'h0000_0000;
        end else if (wd_state_r == WD_FAULT && wd_state_nxt == WD_FAULT) begin
            fault_cnt_r <= fault_cnt_r + 32'h0000_0001;
        end else begin
            fault_cnt_r <= 32'h0000_0000;
        end
    end

    // Expiry events, saturating so software never sees a wrap
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            fault_events_r <= 16'h0000;
        end else if (wd_state_r == WD_ARMED && wd_state_nxt == WD_FAULT &&
                     fault_events_r != 16'hffff) begin
            fault_events_r <= fault_events_r + 16'h0001;
        end
    end

    // Open-drain pins only ever drive low
    assign sys_reset_n_o = 1'b0;
    assign sys_reset_n_oe = rst_oe_r;
    assign wd_fault_n_o = 1'b0;
    assign wd_fault_n_oe = fault_oe_r;

    // Write address and data channels are accepted independently
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            awready_r <= 1'b0;
            aw_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (awready_r && s_axi_awvalid) begin
            awready_r <= 1'b0;
            aw_got_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (aw_got_r && w_got_r && !bvalid_r) begin
            aw_got_r <= 1'b0;
        end else if (!aw_got_r && !bvalid_r) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wready_r <= 1'b0;
            w_got_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (wready_r && s_axi_wvalid) begin
            wready_r <= 1'b0;
            w_got_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (aw_got_r && w_got_r && !bvalid_r) begin
            w_got_r <= 1'b0;
        end else if (!w_got_r && !bvalid_r) begin
            wready_r <= 1'b1;
        end
    end

    // Response one cycle after both halves are held; unmapped gives SLVERR
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= swr_pkg::RESP_OKAY;
        end else if (aw_got_r && w_got_r && !bvalid_r) begin
            bvalid_r <= 1'b1;
            bresp_r <= reg_mapped(aw_addr_r) ? swr_pkg::RESP_OKAY : swr_pkg::RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Control register; only byte lane 0 carries a field
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            inhibit_r <= swr_pkg::CTRL_RESET;
        end else if (aw_got_r && w_got_r && !bvalid_r && aw_addr_r == swr_pkg::REG_CTRL &&
                     w_strb_r[0]) begin
            inhibit_r <= w_data_r[swr_pkg::CTRL_INHIBIT_BIT];
        end
    end

    // Read path answers one cycle after the address is taken
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= swr_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (arready_r && s_axi_arvalid) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= reg_mapped(s_axi_araddr) ? swr_pkg::RESP_OKAY : swr_pkg::RESP_SLVERR;
            rdata_r <= 32'h0000_0000;
            case (s_axi_araddr)
                swr_pkg::REG_STATUS: begin
                    rdata_r[swr_pkg::ST_RESET_BIT] <= rst_oe_r;
                    rdata_r[swr_pkg::ST_FAULT_BIT] <= fault_oe_r;
                    rdata_r[swr_pkg::ST_WDEN_BIT] <= wd_enabled;
                    rdata_r[swr_pkg::ST_EVAL_BIT] <= cfg.done;
                    rdata_r[swr_pkg::ST_EXT_BIT] <= EXTENDED_TIMING;
                    rdata_r[swr_pkg::ST_MODE_LSB +: 2] <= cfg.mode;
                end
                swr_pkg::REG_TIMEOUT: rdata_r <= timeout_cyc;
                swr_pkg::REG_CHARGE: rdata_r <= {16'h0000, cfg.charge};
                swr_pkg::REG_FAULT_CNT: rdata_r <= {16'h0000, fault_events_r};
                swr_pkg::REG_CTRL: rdata_r[swr_pkg::CTRL_INHIBIT_BIT] <= inhibit_r;
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end else if (!rvalid_r) begin
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

endmodule

// >>> swr_properties.sv
// Concurrent checks on the supervisor watchdog reset ports
`timescale 1ns/10ps
module swr_properties #(
    parameter int unsigned RST_HOLD_CYCLES = 20
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic manual_reset_n,
    input wire logic manual_reset_drive,
    input wire logic uv_flag,
    input wire logic wd_enable_select,
    input wire logic wd_kick_in,
    input wire logic sys_reset_n_o,
    input wire logic sys_reset_n_oe,
    input wire logic wd_fault_n_o,
    input wire logic wd_fault_n_oe
);
    logic [15:0] quiet_r;
    logic [15:0] flen_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Cycles since a reset cause was last seen; an undriven manual pin is no cause
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            quiet_r <= '0;
        else if (uv_flag || (manual_reset_drive && !manual_reset_n))
            quiet_r <= '0;
        else if (quiet_r != 16'hffff)
            quiet_r <= quiet_r + 16'h0001;
    end
    // Length of the current fault pulse
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            flen_r <= '0;
        else
            flen_r <= wd_fault_n_oe ? flen_r + 16'h0001 : 16'h0000;
    end
    a_manual_resets: assert property (manual_reset_drive && !manual_reset_n |=> sys_reset_n_oe)
        else $error("manual reset ignored");
    a_uv_resets: assert property (uv_flag |=> sys_reset_n_oe)
        else $error("low supply ignored");
    a_release_due: assert property (quiet_r == 16'(RST_HOLD_CYCLES + 1) |-> !sys_reset_n_oe)
        else $error("reset not released after hold");
    a_hold_kept: assert property ($fell(sys_reset_n_oe) |-> quiet_r == 16'(RST_HOLD_CYCLES + 1))
        else $error("reset released early");
    a_fault_needs_release: assert property ($rose(wd_fault_n_oe) |-> !$past(sys_reset_n_oe))
        else $error("fault during reset");
    a_fault_bounded: assert property (wd_fault_n_oe |-> flen_r < 16'(RST_HOLD_CYCLES))
        else $error("fault pulse too long");
    a_fault_full: assert property ($fell(wd_fault_n_oe) && !sys_reset_n_oe
        |-> flen_r == 16'(RST_HOLD_CYCLES))
        else $error("fault pulse too short");
    a_reset_clears_fault: assert property (sys_reset_n_oe |=> !wd_fault_n_oe)
        else $error("fault kept during reset");
    a_open_drain: assert property (sys_reset_n_o == 1'b0 && wd_fault_n_o == 1'b0)
        else $error("open drain data not low");
    a_disabled_quiet: assert property (!wd_enable_select && !$past(wd_enable_select)
        && !wd_fault_n_oe |=> !wd_fault_n_oe)
        else $error("fault while watchdog disabled");
    a_kick_restarts: assert property ($rose(wd_fault_n_oe)
        |-> !(!$past(wd_kick_in) && $past(wd_kick_in, 2)))
        else $error("expiry despite kick");
endmodule
bind swr_top swr_properties #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) u_swr_properties (
    .sys_clk(sys_clk), .resetn(resetn), .manual_reset_n(manual_reset_n),
    .manual_reset_drive(manual_reset_drive), .uv_flag(uv_flag),
    .wd_enable_select(wd_enable_select), .wd_kick_in(wd_kick_in),
    .sys_reset_n_o(sys_reset_n_o), .sys_reset_n_oe(sys_reset_n_oe),
    .wd_fault_n_o(wd_fault_n_o), .wd_fault_n_oe(wd_fault_n_oe));

// >>> swr_host_model.sv
// Host processor that kicks the watchdog at a chosen period
`timescale 1ns/10ps
module swr_host_model #(
    parameter int unsigned SETUP_CYC = 3000
) (
    input wire logic sys_clk,
    input wire logic kick_en,
    input wire logic [15:0] period,
    output logic wd_kick_in
);
    int unsigned cnt = 0;
    int unsigned setup = 0;
    initial wd_kick_in = 1'b1;
    // setup wait, two-cycle low pulse, one edge per period
    always @(posedge sys_clk) begin
        if (!kick_en) begin
            setup <= 0;
            cnt <= 0;
            wd_kick_in <= 1'b1;
        end else if (setup < SETUP_CYC) begin
            setup <= setup + 1;
        end else begin
            cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
            wd_kick_in <= (cnt >= 2);
        end
    end
endmodule

// >>> supervisor_watchdog_reset_tb.sv
// Self-checking bench for the supervisor watchdog reset block
`timescale 1ns/10ps
module supervisor_watchdog_reset_tb;
    localparam int R = 20;
    logic sys_clk, resetn, manual_reset_n, manual_reset_drive, uv_flag, wd_enable_select;
    logic timeout_cfg_pin, timeout_cfg_pullup, wd_kick_in, kick_en, rst_oe, flt_oe, flt_seen;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, ch, t;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] lfsr, period;
    int n_errors, checked, m, i;
    swr_top #(.RST_HOLD_CYCLES(R), .WD_OPEN_CYCLES(60), .WD_PULLUP_CYCLES(40),
        .EVAL_CYCLES(10), .CAP_EXT_BASE(30)) u_swr_top (
        .sys_clk(sys_clk), .resetn(resetn), .manual_reset_n(manual_reset_n),
        .manual_reset_drive(manual_reset_drive), .uv_flag(uv_flag),
        .wd_enable_select(wd_enable_select), .timeout_cfg_pin(timeout_cfg_pin),
        .timeout_cfg_pullup(timeout_cfg_pullup), .wd_kick_in(wd_kick_in),
        .sys_reset_n_o(), .sys_reset_n_oe(rst_oe), .wd_fault_n_o(), .wd_fault_n_oe(flt_oe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // Short setup wait keeps the run brief
    swr_host_model #(.SETUP_CYC(2)) u_swr_host_model (.sys_clk(sys_clk), .kick_en(kick_en),
        .period(period), .wd_kick_in(wd_kick_in));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Sticky fault flag, cleared by the scenarios
    always @(posedge sys_clk) begin
        if (flt_oe === 1'b1)
            flt_seen <= 1'b1;
    end
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Expected timeout per mode, standard law
    function automatic logic [31:0] exp_to(input logic [1:0] md, input logic [31:0] c);
        return (md == 2'h1) ? 32'h28 : (md == 2'h2) ? c * 32'h40 : 32'h3c;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic final_report();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Write; address and data offered together, waits for the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        lfsr = nx(lfsr);
        awaddr <= a;
        wdata <= d;
        wstrb <= {lfsr[2:0], 1'b1};
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        resp = bresp;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
    endtask
    // Reset with the pin strapped; a capacitor charges for five cycles
    task automatic power_up(input logic cap, input logic pu);
        resetn <= 1'b0;
        timeout_cfg_pin <= ~cap;
        timeout_cfg_pullup <= pu;
        cyc(16);
        resetn <= 1'b1;
        cyc(5);
        timeout_cfg_pin <= 1'b1;
        chk(rst_oe, 1'b1, "reset held");
        cyc(R);
        chk(rst_oe, 1'b0, "reset released");
    endtask
    // Kicked run, then silence until expiry, then fault width
    task automatic wd_run(input logic [31:0] to);
        int n;
        lfsr = nx(lfsr);
        period <= 16'h8 + lfsr % (to[15:0] / 16'h2 - 16'h8);
        flt_seen <= 1'b0;
        kick_en <= 1'b1;
        cyc(3 * to);
        chk(flt_seen, 1'b0, "fault while kicked");
        kick_en <= 1'b0;
        for (n = 0; n < to + 8 && flt_oe !== 1'b1; n++)
            cyc(1);
        chk(n <= to + 4 && n + period + 4 >= to, 1'b1, "expiry time");
        for (n = 0; n < R + 8 && flt_oe === 1'b1; n++)
            cyc(1);
        chk(n, R, "fault width");
    endtask
    // Watchdog on the whole run
    initial begin
        #2000000;
        n_errors++;
        final_report();
    end
    initial begin
        {resetn, uv_flag, manual_reset_drive, kick_en, awvalid, wvalid, bready} = '0;
        {arvalid, rready, flt_seen, timeout_cfg_pullup} = '0;
        {manual_reset_n, wd_enable_select, timeout_cfg_pin} = 3'b111;
        {awaddr, araddr, wdata, wstrb, period} = '0;
        lfsr = 16'h0051;
        for (m = 0; m < 3; m++) begin
            power_up(m == 2, m == 1);
            rd_reg(swr_pkg::REG_CHARGE);
            ch = rd;
            rd_reg(swr_pkg::REG_STATUS);
            chk(32'(rd[6:0]), 32'({2'(m), 5'h0c}), "status");
            rd_reg(swr_pkg::REG_TIMEOUT);
            t = exp_to(2'(m), ch);
            chk(rd, t, "timeout");
            wd_run(t);
        end
        $display("test modes done");
        kick_en <= 1'b1;
        for (i = 0; i < 6; i++) begin
            lfsr = nx(lfsr);
            manual_reset_drive <= (lfsr[1:0] != 2'h1);
            manual_reset_n <= (lfsr[1:0] == 2'h0);
            uv_flag <= (lfsr[1:0] == 2'h0);
            cyc(3 + 32'(lfsr[5:2]));
            chk(rst_oe, 1'b1 ^ (lfsr[1:0] == 2'h1), "cause");
            {manual_reset_n, uv_flag} <= 2'b10;
            cyc(R - 1);
            chk(rst_oe, 1'b1 ^ (lfsr[1:0] == 2'h1), "hold");
            cyc(4);
            chk(rst_oe, 1'b0, "release");
        end
        $display("test causes done");
        kick_en <= 1'b0;
        for (i = 0; i < 400 && flt_oe !== 1'b1; i++)
            cyc(1);
        uv_flag <= 1'b1;
        cyc(3);
        chk(flt_oe, 1'b0, "fault during reset");
        uv_flag <= 1'b0;
        cyc(R + 4);
        wd_enable_select <= 1'b0;
        cyc(2);
        flt_seen <= 1'b0;
        cyc(400);
        chk(flt_seen, 1'b0, "disabled fault");
        rd_reg(swr_pkg::REG_STATUS);
        chk(rd[2], 1'b0, "disabled status");
        wd_enable_select <= 1'b1;
        wr(swr_pkg::REG_CTRL, 32'h1);
        chk(resp, swr_pkg::RESP_OKAY, "ctrl write");
        flt_seen <= 1'b0;
        cyc(400);
        chk(flt_seen, 1'b0, "inhibited fault");
        rd_reg(swr_pkg::REG_CTRL);
        chk(rd, 32'h1, "ctrl readback");
        wr(swr_pkg::REG_TIMEOUT, 32'h0);
        rd_reg(swr_pkg::REG_TIMEOUT);
        chk(rd, t, "read-only timeout");
        rd_reg(8'h20);
        chk({30'h0, resp}, 32'(swr_pkg::RESP_SLVERR), "unmapped read");
        wr(8'h20, 32'h1);
        chk(resp, swr_pkg::RESP_SLVERR, "unmapped write");
        $display("test registers done");
        final_report();
    end
endmodule
